// File: swemr_pkg.sv
/*
 * constants for the write-leveling exit and pattern register readout block:
 * register offsets, field positions, reset values, mode register bits and
 * link-clock counts.
 * assumes: one core clock; all timing counts are in link clock periods.
 */
//
// Behaviour
// - leveling feedback on one prime dq per lane or all; others held low
// - dq outputs undefined from termination off until tMOD after exit command
// - any command accepted after tMOD; next mode command after tMRD
// - mode command to MR3 with A2 set enters pattern mode, clear leaves
// - in pattern mode reads take the MR3 A[1:0] location, never the array
// - in pattern mode read with auto precharge acts as plain read
// - with A2 clear, location bits ignored; reads and writes use the array
// - bit 0 of each lane carries data; upper bits copy it or are zero
// - full pattern burst needs A2 zero, returns positions 0 to 7 ascending
// - chopped pattern read: A2 zero gives positions 0-3, one gives 4-7
// - pattern reads ignore bank bits, A[9:3], A10, A11, A13, A14
// - A12 picks chop on the fly only if MR0 allows; normal latency
// - burst position 0 is location lsb, position 7 its msb
// - location zero holds alternating pattern 0,1,0,1,0,1,0,1
// - MR1 A7 set enters write leveling, clear exits
package swemr_pkg;

   // --------------------------------------------------------------
   // register bus
   // --------------------------------------------------------------
   localparam int BUS_AW = 8;
   localparam int BUS_DW = 32;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0003;
   localparam int CTRL_PRIME_BIT = 0;
   localparam int CTRL_COPY_BIT = 1;
   localparam int STAT_WL_BIT = 0;
   localparam int STAT_MPR_BIT = 1;
   localparam int STAT_LOC_LSB = 2;
   localparam int STAT_UNDEF_BIT = 4;
   localparam int STAT_BUSY_BIT = 5;
   localparam int STAT_BURST_BIT = 6;
   localparam int STAT_FB_BIT = 7;

   // --------------------------------------------------------------
   // command pins and mode register fields
   // --------------------------------------------------------------
   localparam int ADDR_W = 15;
   localparam int BA_W = 3;
   localparam int DQ_W = 16;
   localparam logic [2:0] MR0_SEL = 3'h0;
   localparam logic [2:0] MR1_SEL = 3'h1;
   localparam logic [2:0] MR3_SEL = 3'h3;
   localparam int MR1_WL_BIT = 7;
   localparam int MR3_MPR_BIT = 2;
   localparam int A_AP_BIT = 10;
   localparam int A_BC_BIT = 12;
   localparam int A_NIB_BIT = 2;
   localparam logic [1:0] BL_OTF = 2'h1;
   localparam logic [1:0] BL_BC4 = 2'h2;

   // --------------------------------------------------------------
   // pattern locations and timing counts (link clock periods)
   // --------------------------------------------------------------
   localparam logic [7:0] MPR_LOC0 = 8'hAA;
   localparam logic [7:0] MPR_RFU = 8'h00;
   localparam int T_MOD_NCK = 12;
   localparam int T_MRD_NCK = 4;
   localparam int READ_LAT_NCK = 6;

   // burst engine states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BURST = 2'b10
   } swemr_burst_e;

endpackage : swemr_pkg

// File: swemr_pat_if.sv
/*
 * carrier between the readout engine and the pattern lookup.
 * assumes: the lookup is purely combinational.
 */
`timescale 1ns/1ps
interface swemr_pat_if;
   logic [1:0] loc;
   logic [2:0] pos;
   logic bit_out;

   // engine asks for a location and burst position
   modport src (output loc, output pos, input bit_out);
   // lookup answers with one pattern bit
   modport gen (input loc, input pos, output bit_out);
endinterface : swemr_pat_if

// File: swemr_pattern.sv
/*
 * pattern register lookup: location and burst position to one data bit.
 * assumes: caller registers the result before it reaches a pin.
 */
`timescale 1ns/1ps
module swemr_pattern (
   // pattern request
   swemr_pat_if.gen pat
);
   import swemr_pkg::*;

   // --------------------------------------------------------------
   // location contents
   // --------------------------------------------------------------
   function automatic logic [7:0] loc_word(input logic [1:0] loc);
      loc_word = (loc == 2'h0) ? MPR_LOC0 : MPR_RFU;
   endfunction : loc_word

   logic [7:0] word;

   // position 0 is the lsb, position 7 the msb
   assign word = loc_word(pat.loc);
   assign pat.bit_out = word[pat.pos];
endmodule : swemr_pattern

// File: swemr_top.sv
/*
 * device-side write-leveling feedback and exit, and pattern register
 * readout, sampled on the core clock.
 * assumes: link clock and all pins are asynchronous to core_clk and much
 * slower (at least four core cycles per link half period).
 */
`timescale 1ns/1ps
module swemr_top #(
   parameter int READ_LAT = swemr_pkg::READ_LAT_NCK,
   parameter int MOD_NCK = swemr_pkg::T_MOD_NCK,
   parameter int MRD_NCK = swemr_pkg::T_MRD_NCK
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // link pins from the controller
   input wire logic ck,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [swemr_pkg::BA_W-1:0] ba,
   input wire logic [swemr_pkg::ADDR_W-1:0] addr,
   input wire logic odt,
   input wire logic dqs,
   input wire logic dram_reset_n,
   // data pins toward the controller
   output logic [swemr_pkg::DQ_W-1:0] dq_o,
   output logic [swemr_pkg::DQ_W-1:0] dq_oe_n,
   // array access port
   output logic array_rd,
   output logic array_wr,
   output logic array_ap,
   output logic [swemr_pkg::BA_W-1:0] array_ba,
   output logic [swemr_pkg::ADDR_W-1:0] array_addr,
   input wire logic [swemr_pkg::DQ_W-1:0] array_rdata,
   // register bus
   input wire logic [swemr_pkg::BUS_AW-1:0] bus_addr,
   input wire logic [swemr_pkg::BUS_DW-1:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [swemr_pkg::BUS_DW-1:0] bus_rdata
);
   import swemr_pkg::*;

   localparam int CA_W = 4 + BA_W + ADDR_W;
   localparam logic [3:0] MOD_LOAD = 4'(MOD_NCK);
   localparam logic [2:0] MRD_LOAD = 3'(MRD_NCK);

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   typedef struct packed {
      logic [1:0] ck_s;
      logic [1:0] dqs_s;
      logic [1:0] odt_s;
      logic [1:0] rst_s;
      logic [CA_W-1:0] ca_s1;
      logic [CA_W-1:0] ca_s2;
      logic ck_d;
      logic dqs_d;
      logic [31:0] ctrl;
      logic [1:0] mr0_bl;
      logic wl_on;
      logic mpr_on;
      logic [1:0] loc;
      logic wl_fb;
      logic wl_seen;
      logic undef;
      logic [3:0] mod_cnt;
      logic [2:0] mrd_cnt;
      logic [READ_LAT-1:0][3:0] line;
      swemr_burst_e st;
      logic [2:0] beat;
      logic chop;
      logic hi;
      logic mpr_burst;
      logic [DQ_W-1:0] dq_o;
      logic [DQ_W-1:0] dq_oe_n;
      logic arr_rd;
      logic arr_wr;
      logic arr_ap;
      logic [BA_W-1:0] arr_ba;
      logic [ADDR_W-1:0] arr_addr;
      logic [31:0] rdata;
   } swemr_state_s;

   swemr_state_s r_reg;
   swemr_state_s r_next;
   swemr_pat_if pat ();
   logic [2:0] cur_pos;

   // --------------------------------------------------------------
   // pattern lookup
   // --------------------------------------------------------------
   swemr_pattern u_pattern (
      .pat (pat.gen)
   );

   // burst position of the beat now being shown
   always_comb begin
      if (r_reg.chop) begin
         cur_pos = {r_reg.hi, r_reg.beat[1:0]};
      end else begin
         cur_pos = r_reg.beat;
      end
   end
   assign pat.loc = r_reg.loc;
   assign pat.pos = cur_pos;

   // --------------------------------------------------------------
   // next state
   // --------------------------------------------------------------
   always_comb begin
      logic ck_rise;
      logic ck_edge;
      logic dqs_rise;
      logic is_mrs;
      logic is_rd;
      logic is_wr;
      logic [BA_W-1:0] c_ba;
      logic [ADDR_W-1:0] c_a;
      logic chop;
      logic b;
      logic [3:0] ent;
      ck_rise = 1'b0;
      ck_edge = 1'b0;
      dqs_rise = 1'b0;
      is_mrs = 1'b0;
      is_rd = 1'b0;
      is_wr = 1'b0;
      c_ba = r_reg.ca_s2[ADDR_W +: BA_W];
      c_a = r_reg.ca_s2[ADDR_W-1:0];
      chop = 1'b0;
      b = pat.bit_out;
      ent = 4'h0;
      r_next = r_reg;

      // two-stage synchronisers for every pin
      r_next.ck_s = {r_reg.ck_s[0], ck};
      r_next.dqs_s = {r_reg.dqs_s[0], dqs};
      r_next.odt_s = {r_reg.odt_s[0], odt};
      r_next.rst_s = {r_reg.rst_s[0], dram_reset_n};
      r_next.ca_s1 = {cs_n, ras_n, cas_n, we_n, ba, addr};
      r_next.ca_s2 = r_reg.ca_s1;
      r_next.ck_d = r_reg.ck_s[1];
      r_next.dqs_d = r_reg.dqs_s[1];
      ck_rise = r_reg.ck_s[1] & ~r_reg.ck_d;
      ck_edge = r_reg.ck_s[1] ^ r_reg.ck_d;
      dqs_rise = r_reg.dqs_s[1] & ~r_reg.dqs_d;

      // command decode, acting on link clock rising edges only
      if (ck_rise && !r_reg.ca_s2[CA_W-1]) begin
         unique case (r_reg.ca_s2[CA_W-2 -: 3])
            3'b000: is_mrs = 1'b1;
            3'b101: is_rd = 1'b1;
            3'b100: is_wr = 1'b1;
            default: ;
         endcase
      end
      r_next.arr_rd = 1'b0;
      r_next.arr_wr = 1'b0;

      // link-clock counters guarding the mode change settle time
      if (ck_rise) begin
         if (r_reg.mod_cnt != 4'h0) begin
            r_next.mod_cnt = r_reg.mod_cnt - 4'h1;
         end
         if (r_reg.mrd_cnt != 3'h0) begin
            r_next.mrd_cnt = r_reg.mrd_cnt - 3'h1;
         end
         if (r_reg.mod_cnt == 4'h1 && !r_reg.wl_on) begin
            r_next.undef = 1'b0;
         end
      end

      // mode register commands, next one only after the short delay
      if (is_mrs && r_reg.mrd_cnt == 3'h0) begin
         r_next.mod_cnt = MOD_LOAD;
         r_next.mrd_cnt = MRD_LOAD;
         unique case (c_ba)
            MR0_SEL: r_next.mr0_bl = c_a[1:0];
            MR1_SEL: begin
               r_next.wl_on = c_a[MR1_WL_BIT];
               if (c_a[MR1_WL_BIT] && !r_reg.wl_on) begin
                  r_next.wl_seen = 1'b0;
               end
               if (!c_a[MR1_WL_BIT] && r_reg.wl_on) begin
                  r_next.undef = 1'b1;
               end
            end
            MR3_SEL: begin
               r_next.mpr_on = c_a[MR3_MPR_BIT];
               r_next.loc = c_a[1:0];
            end
            default: ;
         endcase
      end

      // reads and writes wait for the full settle time
      chop = (r_reg.mr0_bl == BL_BC4) ||
             (r_reg.mr0_bl == BL_OTF && !c_a[A_BC_BIT]);
      if (is_rd && r_reg.mod_cnt == 4'h0) begin
         ent = {1'b1, chop, chop & c_a[A_NIB_BIT], r_reg.mpr_on};
         if (!r_reg.mpr_on) begin
            r_next.arr_rd = 1'b1;
            r_next.arr_ap = c_a[A_AP_BIT];
            r_next.arr_ba = c_ba;
            r_next.arr_addr = c_a;
         end
      end
      if (is_wr && r_reg.mod_cnt == 4'h0 && !r_reg.mpr_on) begin
         r_next.arr_wr = 1'b1;
         r_next.arr_ap = c_a[A_AP_BIT];
         r_next.arr_ba = c_ba;
         r_next.arr_addr = c_a;
      end

      // read latency line, then burst beats on every link edge
      if (ck_edge && r_reg.st == ST_BURST) begin
         if (r_reg.beat == (r_reg.chop ? 3'h3 : 3'h7)) begin
            r_next.st = ST_IDLE;
         end else begin
            r_next.beat = r_reg.beat + 3'h1;
         end
      end
      if (ck_rise) begin
         r_next.line = {r_reg.line[READ_LAT-2:0], ent};
         if (r_reg.line[READ_LAT-1][3]) begin
            r_next.st = ST_BURST;
            r_next.beat = 3'h0;
            r_next.chop = r_reg.line[READ_LAT-1][2];
            r_next.hi = r_reg.line[READ_LAT-1][1];
            r_next.mpr_burst = r_reg.line[READ_LAT-1][0];
         end
      end

      // leveling: sample link clock on each strobe rise
      if (r_reg.wl_on && !r_reg.undef && dqs_rise) begin
         r_next.wl_fb = r_reg.ck_s[1];
         r_next.wl_seen = 1'b1;
      end
      if (r_reg.wl_on && r_reg.wl_seen && !r_reg.odt_s[1]) begin
         r_next.undef = 1'b1;
      end

      // data pins
      r_next.dq_oe_n = {DQ_W{1'b1}};
      r_next.dq_o = {DQ_W{1'b0}};
      if (r_reg.undef) begin
         r_next.dq_oe_n = {DQ_W{1'b1}};
      end else if (r_reg.wl_on && r_reg.wl_seen) begin
         r_next.dq_oe_n = {DQ_W{1'b0}};
         if (r_reg.ctrl[CTRL_PRIME_BIT]) begin
            r_next.dq_o = {7'h00, r_reg.wl_fb, 7'h00, r_reg.wl_fb};
         end else begin
            r_next.dq_o = {DQ_W{r_reg.wl_fb}};
         end
      end else if (r_reg.st == ST_BURST) begin
         r_next.dq_oe_n = {DQ_W{1'b0}};
         if (!r_reg.mpr_burst) begin
            r_next.dq_o = array_rdata;
         end else if (r_reg.ctrl[CTRL_COPY_BIT]) begin
            r_next.dq_o = {DQ_W{b}};
         end else begin
            r_next.dq_o = {7'h00, b, 7'h00, b};
         end
      end

      // device reset pin clears leveling and pattern modes; MR0 burst length and location kept
      if (!r_reg.rst_s[1]) begin
         r_next.wl_on = 1'b0;
         r_next.mpr_on = 1'b0;
         r_next.undef = 1'b0;
         r_next.wl_seen = 1'b0;
         r_next.mod_cnt = 4'h0;
         r_next.mrd_cnt = 3'h0;
         r_next.line = '0;
         r_next.st = ST_IDLE;
         r_next.arr_rd = 1'b0;
         r_next.arr_wr = 1'b0;
      end

      // register bus slave
      if (bus_wr && bus_addr == ADDR_CTRL) begin
         r_next.ctrl = bus_wdata & CTRL_MASK;
      end
      r_next.rdata = 32'h0000_0000;
      if (bus_rd) begin
         if (bus_addr == ADDR_CTRL) begin
            r_next.rdata = r_reg.ctrl;
         end else if (bus_addr == ADDR_STATUS) begin
            r_next.rdata[STAT_WL_BIT] = r_reg.wl_on;
            r_next.rdata[STAT_MPR_BIT] = r_reg.mpr_on;
            r_next.rdata[STAT_LOC_LSB +: 2] = r_reg.loc;
            r_next.rdata[STAT_UNDEF_BIT] = r_reg.undef;
            r_next.rdata[STAT_BUSY_BIT] = (r_reg.mod_cnt != 4'h0);
            r_next.rdata[STAT_BURST_BIT] = (r_reg.st == ST_BURST);
            r_next.rdata[STAT_FB_BIT] = r_reg.wl_fb;
         end
      end
   end

   // --------------------------------------------------------------
   // state register
   // --------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         r_reg <= '0;
         r_reg.st <= ST_IDLE;
         r_reg.ctrl <= CTRL_RESET;
         r_reg.dq_oe_n <= {DQ_W{1'b1}};
      end else begin
         r_reg <= r_next;
      end
   end

   // outputs straight from flip-flops
   assign dq_o = r_reg.dq_o;
   assign dq_oe_n = r_reg.dq_oe_n;
   assign array_rd = r_reg.arr_rd;
   assign array_wr = r_reg.arr_wr;
   assign array_ap = r_reg.arr_ap;
   assign array_ba = r_reg.arr_ba;
   assign array_addr = r_reg.arr_addr;
   assign bus_rdata = r_reg.rdata;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   AST_WL_PRIME_LOW: assert property (
      (r_reg.wl_on && r_reg.wl_seen && !r_reg.undef &&
       r_reg.ctrl[CTRL_PRIME_BIT] && r_reg.st == ST_IDLE) |=>
      (dq_o[15:9] == 7'h00 && dq_o[7:1] == 7'h00 && dq_oe_n == 16'h0000))
      else $error("leveling upper dq not low");
   AST_UNDEF_HIZ: assert property (
      $past(r_reg.undef) && r_reg.undef |-> dq_oe_n == 16'hFFFF)
      else $error("dq driven while undefined");
   AST_MOD_WAIT: assert property (
      $rose(r_reg.mod_cnt == 4'h0) && $past(r_reg.rst_s[1]) |->
      $past(r_reg.mod_cnt) == 4'h1)
      else $error("settle counter skipped");
   AST_MPR_ENTER: assert property (
      (r_reg.ca_s2[CA_W-1 -: 4] == 4'b0000 && r_reg.ck_s[1] &&
       !r_reg.ck_d && r_reg.mrd_cnt == 3'h0 && r_reg.rst_s[1] &&
       r_reg.ca_s2[ADDR_W +: BA_W] == MR3_SEL) |=>
      r_reg.mpr_on == $past(r_reg.ca_s2[MR3_MPR_BIT]))
      else $error("pattern mode not tracking MR3");
   AST_NO_ARRAY_IN_MPR: assert property (
      (array_rd || array_wr) |-> !$past(r_reg.mpr_on))
      else $error("array touched in pattern mode");
   AST_LANE_FORM: assert property (
      ($past(r_reg.st) == ST_BURST && $past(r_reg.mpr_burst) &&
       !$past(r_reg.undef) && !$past(r_reg.wl_on)) |->
      (dq_o[15:9] == {7{dq_o[8]}} || dq_o[15:9] == 7'h00) &&
      dq_o[8] == dq_o[0])
      else $error("pattern lane form wrong");
   AST_NIBBLE_HI: assert property (
      (r_reg.st == ST_BURST && r_reg.chop) |->
      !r_reg.beat[2] && pat.pos == {r_reg.hi, r_reg.beat[1:0]})
      else $error("upper nibble order wrong");
   AST_LOC0_PATTERN: assert property (
      (r_reg.st == ST_BURST && r_reg.mpr_burst && r_reg.loc == 2'h0 &&
       !r_reg.wl_on && !r_reg.undef) |=> dq_o[0] == $past(cur_pos[0]))
      else $error("location zero pattern wrong");
   AST_RESET_MPR: assert property (
      !r_reg.rst_s[1] |=> !r_reg.mpr_on && !r_reg.wl_on)
      else $error("reset left a mode on");
endmodule : swemr_top

// File: swemr_ctl_model.sv
/*
 * controller model on the link side: commands, strobe, odt, reset pin.
 * assumes: ck runs free from the bench; tasks are called by tb_top.
 */
`timescale 1ns/1ps
module swemr_ctl_model #(
   parameter int MOD = swemr_pkg::T_MOD_NCK,
   parameter int TRP = 3,
   parameter int TMPRR = 2
) (
   // link clock
   input wire logic ck,
   // command pins cs_n, ras_n, cas_n, we_n
   output logic [3:0] cmd_n,
   output logic [swemr_pkg::BA_W-1:0] ba,
   output logic [swemr_pkg::ADDR_W-1:0] addr,
   // termination, strobe and reset
   output logic odt,
   output logic dqs,
   output logic dram_reset_n
);
   import swemr_pkg::*;
   // -----------------------------------------------------------
   // pin drivers
   // -----------------------------------------------------------
   // idle pins at time zero
   initial begin
      cmd_n = 4'hf;
      ba = '0;
      addr = '0;
      odt = 1'b0;
      dqs = 1'b0;
      dram_reset_n = 1'b1;
   end
   // one command across a ck rise; lines flip once deselected
   task automatic cmd(input logic [3:0] c, input logic [BA_W-1:0] b,
      input logic [ADDR_W-1:0] a);
      @(negedge ck);
      cmd_n <= c;
      ba <= b;
      addr <= a;
      @(negedge ck);
      cmd_n <= 4'hf;
      ba <= ~b;
      addr <= ~a;
   endtask : cmd
   // mode command, then the settle time
   task automatic mrs(input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a);
      cmd(4'h0, b, a);
      repeat (MOD + 1) @(posedge ck);
   endtask : mrs
   // precharge all, wait, then enter pattern mode
   task automatic mpr_on(input logic [1:0] loc);
      cmd(4'h2, '0, 15'h0400);
      repeat (TRP) @(posedge ck);
      mrs(MR3_SEL, {13'h0001, loc});
   endtask : mpr_on
   // wait after the last burst, then leave pattern mode
   task automatic mpr_off(input logic [1:0] loc);
      repeat (TMPRR) @(posedge ck);
      mrs(MR3_SEL, {13'h0000, loc});
   endtask : mpr_off
   // one strobe rise with ck high or low; strobe released after it
   task automatic strobe(input logic hi);
      if (hi) begin
         @(posedge ck);
      end else begin
         @(negedge ck);
      end
      #40 dqs <= 1'b1;
      #40 dqs <= 1'b0;
   endtask : strobe
   task automatic set_odt(input logic v);
      @(negedge ck);
      odt <= v;
   endtask : set_odt
   // termination off first, then the exit command
   task automatic wl_exit();
      @(negedge ck);
      odt <= 1'b0;
      repeat (2) @(posedge ck);
      cmd(4'h0, MR1_SEL, '0);
   endtask : wl_exit
   // short pulse on the device reset pin
   task automatic dev_reset();
      @(negedge ck);
      dram_reset_n <= 1'b0;
      repeat (2) @(negedge ck);
      dram_reset_n <= 1'b1;
      repeat (4) @(posedge ck);
   endtask : dev_reset
endmodule : swemr_ctl_model

// File: tb_top.sv
/*
 * self-checking bench for swemr_top driven by the controller model.
 * assumes: package, pattern lookup, top and model compiled before it.
 */
`timescale 1ns/1ps
module tb_top;
   import swemr_pkg::*;
   localparam int RL = 6;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic ck = 1'b0;
   logic [3:0] cmd_n;
   logic [BA_W-1:0] ba, array_ba;
   logic [ADDR_W-1:0] addr, array_addr;
   logic odt, dqs, dram_reset_n, array_rd, array_wr, array_ap;
   logic [DQ_W-1:0] dq_o, dq_oe_n, array_rdata = '0, rdval = '0;
   logic [BUS_AW-1:0] bus_addr = '0;
   logic [BUS_DW-1:0] bus_wdata = '0, bus_rdata, d;
   logic bus_wr = 1'b0, bus_rd = 1'b0, mpr = 1'b0, copy = 1'b0;
   logic [1:0] loc = 2'b00;
   int err_count = 0, checked = 0, tests = 0, rd_cnt = 0, wr_cnt = 0;
   int seed, n;
   // -----------------------------------------------------------
   // clocks, array side and instances
   // -----------------------------------------------------------
   always #10 core_clk = ~core_clk;
   // link clock, phase offset from the core clock
   initial begin
      #3;
      forever #80 ck = ~ck;
   end
   // array data source and access counters
   always @(posedge core_clk) begin
      array_rdata <= rdval;
      if (array_rd === 1'b1) rd_cnt <= rd_cnt + 1;
      if (array_wr === 1'b1) wr_cnt <= wr_cnt + 1;
   end
   swemr_top #(.READ_LAT(RL), .MOD_NCK(T_MOD_NCK), .MRD_NCK(T_MRD_NCK))
   u_swemr_top (.core_clk(core_clk), .nrst(nrst), .ck(ck),
      .cs_n(cmd_n[3]), .ras_n(cmd_n[2]), .cas_n(cmd_n[1]), .we_n(cmd_n[0]),
      .ba(ba), .addr(addr), .odt(odt), .dqs(dqs),
      .dram_reset_n(dram_reset_n), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
      .array_rd(array_rd), .array_wr(array_wr), .array_ap(array_ap),
      .array_ba(array_ba), .array_addr(array_addr),
      .array_rdata(array_rdata), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata));
   swemr_ctl_model #(.MOD(T_MOD_NCK)) u_swemr_ctl_model (.ck(ck),
      .cmd_n(cmd_n), .ba(ba), .addr(addr), .odt(odt), .dqs(dqs),
      .dram_reset_n(dram_reset_n));
   // -----------------------------------------------------------
   // tasks
   // -----------------------------------------------------------
   task automatic chk_reg(input logic [31:0] g, e, input string m);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk_reg
   task automatic chk_pin(input logic [15:0] g, e, input string m);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk_pin
   task automatic bus_write(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      bus_addr <= a;
      bus_wdata <= v;
      bus_wr <= 1'b1;
      @(posedge core_clk);
      bus_wr <= 1'b0;
   endtask : bus_write
   // read one word and compare the masked bits
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e,
      input string s);
      @(posedge core_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge core_clk);
      bus_rd <= 1'b0;
      @(negedge core_clk);
      chk_reg(bus_rdata & m, e, s);
   endtask : rd_chk
   task automatic end_test(input string s);
      tests++;
      $display("test %s done", s);
   endtask : end_test
   // expected dq for one beat: alternating bits at location zero
   function automatic logic [15:0] exp_dq(input logic [2:0] pos);
      logic bt;
      bt = (loc == 2'b00) & pos[0];
      if (!mpr) return rdval;
      return copy ? {16{bt}} : {7'h00, bt, 7'h00, bt};
   endfunction : exp_dq
   // one read with random don't-care bits; every beat is compared
   task automatic do_read(input logic ap, a12, a2, input int nb);
      logic [ADDR_W-1:0] a;
      int n0;
      a = ADDR_W'($urandom);
      a[A_AP_BIT] = ap;
      a[A_BC_BIT] = a12;
      a[2:0] = {a2, 2'b00};
      n0 = rd_cnt;
      u_swemr_ctl_model.cmd(4'h5, BA_W'($urandom), a);
      repeat (RL) @(posedge ck);
      #110;
      for (int i = 0; i < nb; i++) begin
         chk_pin(dq_o, exp_dq(nb == 8 ? 3'(i) : {a2, 2'(i)}), "beat");
         chk_pin(dq_oe_n, 16'h0000, "beat drive");
         #80;
      end
      #40;
      chk_pin(dq_oe_n, 16'hffff, "release");
      chk_pin(16'(rd_cnt - n0), {15'h0, !mpr}, "array read");
      chk_pin({15'h0, array_ap}, 16'h0, "no precharge");
      if (!mpr) chk_pin({1'b0, array_addr}, {1'b0, a}, "addr");
   endtask : do_read
   task automatic complete_run();
      $display("tests %0d checked %0d mismatches %0d", tests, checked,
         err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run
   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial begin
      #1900000;
      err_count++;
      $display("mismatch at %0t: run limit reached", $time);
      complete_run();
   end
   initial begin
      seed = $urandom(90928);
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      rd_chk(ADDR_CTRL, '1, CTRL_RESET, "ctrl reset");
      rd_chk(ADDR_STATUS, '1, 32'h0, "status reset");
      chk_pin(dq_oe_n, 16'hffff, "oe reset");
      end_test("reset");
      d = $urandom;
      bus_write(ADDR_CTRL, d);
      rd_chk(ADDR_CTRL, '1, d & CTRL_MASK, "ctrl rw");
      rd_chk(8'h0c, '1, 32'h0, "unmapped");
      bus_write(ADDR_STATUS, '1);
      rd_chk(ADDR_STATUS, '1, 32'h0, "status ro");
      end_test("registers");
      // fixed eight-beat bursts, both lane fill modes, RD and RDA
      repeat (20) @(posedge ck);
      u_swemr_ctl_model.mrs(MR0_SEL, '0);
      u_swemr_ctl_model.mpr_on(2'b00);
      mpr = 1'b1;
      rd_chk(ADDR_STATUS, '1, 32'h2, "mpr on");
      for (int k = 0; k < 4; k++) begin
         copy = k[1];
         bus_write(ADDR_CTRL, {30'h0, copy, 1'b1});
         do_read(k[0], 1'($urandom), 1'b0, 8);
      end
      end_test("bl8");
      // chop on the fly, both nibbles, then full burst by A12
      u_swemr_ctl_model.mpr_off(2'($urandom));
      u_swemr_ctl_model.mrs(MR0_SEL, 15'(BL_OTF));
      u_swemr_ctl_model.mpr_on(2'b00);
      do_read(1'b0, 1'b0, 1'b0, 4);
      do_read(1'b1, 1'b0, 1'b1, 4);
      do_read(1'b0, 1'b1, 1'b0, 8);
      // fixed chop: A12 set, still four beats
      u_swemr_ctl_model.mpr_off(2'b00);
      u_swemr_ctl_model.mrs(MR0_SEL, 15'(BL_BC4));
      u_swemr_ctl_model.mpr_on(2'b00);
      do_read(1'b0, 1'b1, 1'b1, 4);
      end_test("bc4");
      u_swemr_ctl_model.mpr_off(2'b00);
      u_swemr_ctl_model.mrs(MR0_SEL, 15'(BL_OTF));
      loc = 2'b11;
      u_swemr_ctl_model.mpr_on(loc);
      rd_chk(ADDR_STATUS, '1, 32'h0e, "location");
      do_read(1'b0, 1'b1, 1'b0, 8);
      end_test("location");
      // leave with location bits set: array traffic again
      u_swemr_ctl_model.mpr_off(2'b11);
      mpr = 1'b0;
      rd_chk(ADDR_STATUS, '1, 32'h0c, "mpr off");
      rdval = 16'($urandom);
      do_read(1'b0, 1'b1, 1'b0, 8);
      u_swemr_ctl_model.cmd(4'h4, '0, '0);
      repeat (4) @(negedge ck);
      chk_pin(16'(wr_cnt), 16'h1, "array write");
      end_test("normal");
      loc = 2'b00;
      u_swemr_ctl_model.mpr_on(loc);
      rd_chk(ADDR_STATUS, '1, 32'h2, "mpr again");
      u_swemr_ctl_model.dev_reset();
      rd_chk(ADDR_STATUS, '1, 32'h0, "device reset");
      do_read(1'b0, 1'b1, 1'b0, 8);
      end_test("device reset");
      // leveling: prime high, prime low, all bits high
      u_swemr_ctl_model.mrs(MR1_SEL, 15'h0080);
      u_swemr_ctl_model.set_odt(1'b1);
      for (int k = 0; k < 3; k++) begin
         bus_write(ADDR_CTRL, {31'h0, k != 2});
         u_swemr_ctl_model.strobe(k != 1);
         repeat (10) @(negedge core_clk);
         chk_pin(dq_o, k == 0 ? 16'h0101 : k == 1 ? 16'h0 : 16'hffff, "lvl");
         chk_pin(dq_oe_n, 16'h0000, "level drive");
      end
      rd_chk(ADDR_STATUS, 32'h81, 32'h81, "wl on");
      n = rd_cnt;
      u_swemr_ctl_model.wl_exit();
      rd_chk(ADDR_STATUS, 32'h31, 32'h30, "exit undefined");
      chk_pin(dq_oe_n, 16'hffff, "undefined released");
      u_swemr_ctl_model.cmd(4'h5, '0, 15'h1000);
      repeat (T_MOD_NCK + 1) @(posedge ck);
      chk_pin(16'(rd_cnt - n), 16'h0, "read in settle");
      rd_chk(ADDR_STATUS, 32'h31, 32'h0, "settled");
      do_read(1'b0, 1'b1, 1'b0, 8);
      end_test("leveling");
      complete_run();
   end
endmodule : tb_top
